// >>> src/pm_seq_pkg.sv
// Constants, types and register map shared by the power mode sequencer files.
package pm_seq_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ          = 200;
    localparam int SLEEP_RESUME_NS  = 15000;
    localparam int HIB_RESUME_NS    = 100000;
    localparam int TICK_UNIT_NS     = 1000;
    // Least time, rounded up.
    localparam int SLEEP_RESUME_CYC = (SLEEP_RESUME_NS * CLK_MHZ + 999) / 1000;
    // Strictly under the limit, so one cycle short of it.
    localparam int HIB_RESUME_CYC   = HIB_RESUME_NS * CLK_MHZ / 1000 - 1;
    localparam int TICK_DIV_CYC     = TICK_UNIT_NS * CLK_MHZ / 1000;
    localparam int CNT_W            = 16;
    localparam int TICK_W           = 16;

    // ==========================================================
    // Register map
    localparam int ADR_W = 8;
    localparam logic [7:0] OFS_ACT_TMPL   = 8'h00;
    localparam logic [7:0] OFS_ALT_TMPL   = 8'h04;
    localparam logic [7:0] OFS_MODE       = 8'h08;
    localparam logic [7:0] OFS_WAKE_EN    = 8'h0C;
    localparam logic [7:0] OFS_WAKE_CAUSE = 8'h10;
    localparam logic [7:0] OFS_TICK_PER   = 8'h14;

    localparam logic [15:0] TICK_PER_RST = 16'h03E8;
    localparam logic [6:0]  WAKE_EN_RST  = 7'h7F;

    // ==========================================================
    // Resource and wake source layout
    localparam int RES_CPU   = 0;
    localparam int N_WAKE    = 7;
    localparam int WK_PERIPH = 0;
    localparam int WK_SUPV   = 1;
    localparam int WK_TICK   = 2;
    localparam int WK_IO     = 3;
    localparam int WK_EXTRST = 4;
    localparam int WK_WDOG   = 5;
    localparam int WK_PREC   = 6;

    // ==========================================================
    // Mode commands and modes
    localparam int CMD_W = 3;
    localparam logic [2:0] CMD_ACTIVE = 3'h1;
    localparam logic [2:0] CMD_ALT    = 3'h2;
    localparam logic [2:0] CMD_SLEEP  = 3'h3;
    localparam logic [2:0] CMD_HIB    = 3'h4;

    typedef enum logic [2:0]
    {
        M_ACTIVE = 3'h0,
        M_ALT    = 3'h1,
        M_SLEEP  = 3'h2,
        M_HIB    = 3'h3,
        M_RESUME = 3'h4
    } mode_t;

endpackage

// >>> src/pm_sync.sv
// Two flip-flop synchroniser bank for asynchronous wake inputs.
`timescale 1ns/10ps
module pm_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_st_t;

    sync_st_t st_ff;
    sync_st_t nxt_st;

    // ==========================================================
    // Synchroniser
    always_comb
    begin
        nxt_st.meta = d;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= '{meta: RST_VAL, sync: RST_VAL};
        else
            st_ff <= nxt_st;
    end

    assign q = st_ff.sync;

endmodule

// >>> src/pm_tick.sv
// Central periodic tick: microsecond prescaler and programmable period.
`timescale 1ns/10ps
module pm_tick #(
    parameter int DIV_CYC = pm_seq_pkg::TICK_DIV_CYC
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Control
    input  wire logic                          run,
    input  wire logic [pm_seq_pkg::TICK_W-1:0] period,
    // Periodic event
    output logic                               tick
);

    localparam int DIV_W = $clog2(DIV_CYC);
    localparam int TW    = pm_seq_pkg::TICK_W;

    typedef struct packed
    {
        logic [DIV_W-1:0] div;
        logic [TW-1:0]    cnt;
        logic             tick;
    } tick_st_t;

    tick_st_t st_ff;
    tick_st_t nxt_st;

    // ==========================================================
    // Prescaler and period counter
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (!run)
        begin
            nxt_st.div = '0;
            nxt_st.cnt = '0;
        end
        else if (st_ff.div == DIV_W'(DIV_CYC - 1))
        begin
            nxt_st.div = '0;
            // A period of zero behaves as one microsecond.
            if ({1'b0, st_ff.cnt} + (TW+1)'(1) >= {1'b0, period})
            begin
                nxt_st.cnt  = '0;
                nxt_st.tick = 1'b1;
            end
            else
                nxt_st.cnt = st_ff.cnt + TW'(1);
        end
        else
            nxt_st.div = st_ff.div + DIV_W'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;

endmodule

// >>> src/pm_seq.sv
// Global power mode sequencer with Wishbone register access.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
module pm_seq #(
    parameter int N_RES          = 8,
    parameter int N_PERIPH       = 4,
    parameter int HIB_RESUME_CYC = pm_seq_pkg::HIB_RESUME_CYC
) (
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RSTN,
    // Wishbone slave
    input  wire logic                          CYC_I,
    input  wire logic                          STB_I,
    input  wire logic                          WE_I,
    input  wire logic [pm_seq_pkg::ADR_W-1:0]  ADR_I,
    input  wire logic [3:0]                    SEL_I,
    input  wire logic [31:0]                   DAT_I,
    output logic      [31:0]                   DAT_O,
    output logic                               ACK_O,
    // Wake sources
    input  wire logic [N_PERIPH-1:0]           PERIPH_IRQ,
    input  wire logic                          SUPV_IRQ,
    input  wire logic                          IO_IRQ,
    input  wire logic                          EXTERNAL_RESET_PIN_N,
    input  wire logic                          WATCHDOG_TIMEOUT,
    input  wire logic                          PRECISION_SUPPLY_RESET,
    // Power controls
    output logic      [N_RES-1:0]              RES_CLK_EN,
    output logic      [N_RES-1:0]              RES_BIAS_EN,
    output logic                               CPU_EN,
    output logic                               REG_LOW_POWER,
    output logic                               PIN_HOLD,
    output logic                               SRAM_RETAIN,
    output logic                               TICK_IRQ,
    output logic      [2:0]                    POWER_MODE
);

    localparam int NW = pm_seq_pkg::N_WAKE;
    localparam int CW = pm_seq_pkg::CNT_W;
    localparam int TW = pm_seq_pkg::TICK_W;

    typedef struct packed
    {
        pm_seq_pkg::mode_t mode;
        logic              from_hib;
        logic              booted;
        logic [CW-1:0]     wait_cnt;
        logic [N_RES-1:0]  act;
        logic [N_RES-1:0]  alt;
        logic [NW-1:0]     wk_en;
        logic [NW-1:0]     cause;
        logic [TW-1:0]     tick_per;
        logic              ack;
        logic [31:0]       rdata;
        logic [N_RES-1:0]  res_en;
        logic              lowp;
        logic              hold;
        logic              retain;
    } st_t;

    localparam st_t ST_RST = '{
        mode:     pm_seq_pkg::M_ACTIVE,
        from_hib: 1'b0,
        booted:   1'b0,
        wait_cnt: '0,
        act:      '1,
        alt:      '0,
        wk_en:    pm_seq_pkg::WAKE_EN_RST,
        cause:    '0,
        tick_per: pm_seq_pkg::TICK_PER_RST,
        ack:      1'b0,
        rdata:    '0,
        res_en:   '1,
        lowp:     1'b0,
        hold:     1'b0,
        retain:   1'b0
    };

    st_t            st_ff;
    st_t            nxt_st;
    logic [NW-1:0]  src;
    logic [NW-1:0]  ev;
    logic           wake;
    logic           req;
    logic           wr_go;
    logic           go_low;
    logic [2:0]     cmd;
    logic [31:0]    rd;
    logic [N_RES-1:0] tmpl;
    logic           supv_s;
    logic           io_s;
    logic           xrst_n_s;
    logic           wdog_s;
    logic           prec_s;
    logic           tick;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[8*i +: 8] = dat[8*i +: 8];
        end
        return res;
    endfunction

    // ==========================================================
    // Wake source capture
    // Pins, the supervisor and the watchdog come from other clocks.
    pm_sync #(
        .W       (5),
        .RST_VAL (5'h04)
    ) u_sync (
        .clk   (CLK),
        .rst_n (RSTN),
        .d     ({PRECISION_SUPPLY_RESET, WATCHDOG_TIMEOUT,
                 EXTERNAL_RESET_PIN_N, IO_IRQ, SUPV_IRQ}),
        .q     ({prec_s, wdog_s, xrst_n_s, io_s, supv_s})
    );

    // The tick stops in hibernate, where only pin interrupts may wake.
    pm_tick u_tick (
        .clk    (CLK),
        .rst_n  (RSTN),
        .run    (st_ff.mode != pm_seq_pkg::M_HIB),
        .period (st_ff.tick_per),
        .tick   (tick)
    );

    always_comb
    begin
        src                        = '0;
        src[pm_seq_pkg::WK_PERIPH] = |PERIPH_IRQ;
        src[pm_seq_pkg::WK_SUPV]   = supv_s;
        src[pm_seq_pkg::WK_TICK]   = tick;
        src[pm_seq_pkg::WK_IO]     = io_s;
        src[pm_seq_pkg::WK_EXTRST] = ~xrst_n_s;
        src[pm_seq_pkg::WK_WDOG]   = wdog_s;
        src[pm_seq_pkg::WK_PREC]   = prec_s;
    end

    assign ev   = src & st_ff.wk_en;
    assign wake = |ev;

    // ==========================================================
    // Bus decode
    // A write commits on the edge at which the master sees ACK_O.
    assign req   = CYC_I & STB_I;
    assign wr_go = req & WE_I & st_ff.ack;
    assign cmd   = DAT_I[pm_seq_pkg::CMD_W-1:0];
    assign go_low = wr_go & SEL_I[0] & (ADR_I == pm_seq_pkg::OFS_MODE)
                  & ((cmd == pm_seq_pkg::CMD_SLEEP) | (cmd == pm_seq_pkg::CMD_HIB));

    always_comb
    begin
        rd = '0;
        case (ADR_I)
            pm_seq_pkg::OFS_ACT_TMPL:   rd = 32'(st_ff.act);
            pm_seq_pkg::OFS_ALT_TMPL:   rd = 32'(st_ff.alt);
            pm_seq_pkg::OFS_MODE:       rd = 32'(st_ff.mode);
            pm_seq_pkg::OFS_WAKE_EN:    rd = 32'(st_ff.wk_en);
            pm_seq_pkg::OFS_WAKE_CAUSE: rd = 32'(st_ff.cause);
            pm_seq_pkg::OFS_TICK_PER:   rd = 32'(st_ff.tick_per);
            default:                    rd = '0;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.booted = 1'b1;
        nxt_st.ack    = req & ~st_ff.ack;
        if (req & ~st_ff.ack)
            nxt_st.rdata = rd;

        // Configuration writes; a template write reaches the enables at the same edge.
        if (wr_go)
        begin
            case (ADR_I)
                pm_seq_pkg::OFS_ACT_TMPL:
                    nxt_st.act = N_RES'(merge(32'(st_ff.act), DAT_I, SEL_I));
                pm_seq_pkg::OFS_ALT_TMPL:
                    nxt_st.alt = N_RES'(merge(32'(st_ff.alt), DAT_I, SEL_I));
                pm_seq_pkg::OFS_WAKE_EN:
                    nxt_st.wk_en = NW'(merge(32'(st_ff.wk_en), DAT_I, SEL_I));
                pm_seq_pkg::OFS_TICK_PER:
                    nxt_st.tick_per = TW'(merge(32'(st_ff.tick_per), DAT_I, SEL_I));
                pm_seq_pkg::OFS_WAKE_CAUSE:
                    if (SEL_I[0])
                        nxt_st.cause = st_ff.cause & ~DAT_I[NW-1:0];
                default:
                    nxt_st.rdata = nxt_st.rdata;
            endcase
        end
        // A new event outranks a clear in the same cycle.
        nxt_st.cause = nxt_st.cause | ev;

        unique case (st_ff.mode)
            pm_seq_pkg::M_ACTIVE,
            pm_seq_pkg::M_ALT:
            begin
                if (wake)
                begin
                    nxt_st.mode                = pm_seq_pkg::M_ACTIVE;
                    nxt_st.act[pm_seq_pkg::RES_CPU] = 1'b1;
                end
                else if (wr_go & SEL_I[0] & (ADR_I == pm_seq_pkg::OFS_MODE))
                begin
                    case (cmd)
                        pm_seq_pkg::CMD_ACTIVE: nxt_st.mode = pm_seq_pkg::M_ACTIVE;
                        pm_seq_pkg::CMD_ALT:    nxt_st.mode = pm_seq_pkg::M_ALT;
                        pm_seq_pkg::CMD_SLEEP:  nxt_st.mode = pm_seq_pkg::M_SLEEP;
                        pm_seq_pkg::CMD_HIB:    nxt_st.mode = pm_seq_pkg::M_HIB;
                        default:                nxt_st.mode = st_ff.mode;
                    endcase
                end
            end
            pm_seq_pkg::M_SLEEP:
            begin
                if (wake)
                begin
                    nxt_st.mode     = pm_seq_pkg::M_RESUME;
                    nxt_st.from_hib = 1'b0;
                    nxt_st.wait_cnt = CW'(pm_seq_pkg::SLEEP_RESUME_CYC - 1);
                end
            end
            pm_seq_pkg::M_HIB:
            begin
                if (ev[pm_seq_pkg::WK_IO])
                begin
                    nxt_st.mode     = pm_seq_pkg::M_RESUME;
                    nxt_st.from_hib = 1'b1;
                    nxt_st.wait_cnt = CW'(HIB_RESUME_CYC - 1);
                end
            end
            pm_seq_pkg::M_RESUME:
            begin
                if (st_ff.wait_cnt == '0)
                begin
                    nxt_st.mode                = pm_seq_pkg::M_ACTIVE;
                    nxt_st.act[pm_seq_pkg::RES_CPU] = 1'b1;
                end
                else
                    nxt_st.wait_cnt = st_ff.wait_cnt - CW'(1);
            end
            default:
                nxt_st.mode = pm_seq_pkg::M_ACTIVE;
        endcase

        // Outputs follow the next mode so they change with it.
        unique case (nxt_st.mode)
            pm_seq_pkg::M_ACTIVE: tmpl = nxt_st.act;
            pm_seq_pkg::M_ALT:    tmpl = nxt_st.alt;
            default:              tmpl = '0;
        endcase
        nxt_st.res_en = tmpl;
        nxt_st.lowp   = (nxt_st.mode == pm_seq_pkg::M_SLEEP) | (nxt_st.mode == pm_seq_pkg::M_HIB);
        // Outputs stay held until the hibernate resume finishes.
        nxt_st.hold   = (nxt_st.mode == pm_seq_pkg::M_HIB)
                      | ((nxt_st.mode == pm_seq_pkg::M_RESUME) & nxt_st.from_hib);
        nxt_st.retain = nxt_st.lowp | (nxt_st.mode == pm_seq_pkg::M_RESUME);
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    // ==========================================================
    // Outputs
    assign DAT_O         = st_ff.rdata;
    assign ACK_O         = st_ff.ack;
    assign RES_CLK_EN    = st_ff.res_en;
    assign RES_BIAS_EN   = st_ff.res_en;
    assign CPU_EN        = st_ff.res_en[pm_seq_pkg::RES_CPU];
    assign REG_LOW_POWER = st_ff.lowp;
    assign PIN_HOLD      = st_ff.hold;
    assign SRAM_RETAIN   = st_ff.retain;
    assign TICK_IRQ      = tick;
    assign POWER_MODE    = st_ff.mode;

    // ==========================================================
    // Assertions
    localparam int SLP_M1 = pm_seq_pkg::SLEEP_RESUME_CYC - 1;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    a_boot_active: assert property (!st_ff.booted |-> st_ff.mode == pm_seq_pkg::M_ACTIVE && CPU_EN)
        else $error("not active with cpu after reset");
    a_active_tmpl: assert property (st_ff.mode == pm_seq_pkg::M_ACTIVE |-> RES_CLK_EN == st_ff.act)
        else $error("active enables differ from template");
    a_alt_tmpl: assert property (st_ff.mode == pm_seq_pkg::M_ALT |-> RES_CLK_EN == st_ff.alt)
        else $error("alternate enables differ from template");
    a_gate_bias: assert property (RES_BIAS_EN == RES_CLK_EN)
        else $error("bias enable does not follow clock gate");
    a_low_off: assert property (st_ff.mode == pm_seq_pkg::M_SLEEP || st_ff.mode == pm_seq_pkg::M_HIB
                                |-> RES_CLK_EN == '0 && REG_LOW_POWER)
        else $error("resources alive in low power mode");
    a_wake_cpu: assert property ((st_ff.mode == pm_seq_pkg::M_ACTIVE || st_ff.mode == pm_seq_pkg::M_ALT)
                                 && wake |=> st_ff.mode == pm_seq_pkg::M_ACTIVE && CPU_EN)
        else $error("wakeup did not restore active with cpu");
    a_sleep_resume: assert property (st_ff.mode == pm_seq_pkg::M_SLEEP && wake
                                     |=> st_ff.mode == pm_seq_pkg::M_RESUME && st_ff.wait_cnt == CW'(SLP_M1))
        else $error("sleep resume wait wrong");
    a_resume_end: assert property (st_ff.mode == pm_seq_pkg::M_RESUME && st_ff.wait_cnt == '0
                                   |=> st_ff.mode == pm_seq_pkg::M_ACTIVE && CPU_EN)
        else $error("resume did not end in active");
    a_hib_only_io: assert property (st_ff.mode == pm_seq_pkg::M_HIB && !ev[pm_seq_pkg::WK_IO]
                                    |=> st_ff.mode == pm_seq_pkg::M_HIB)
        else $error("hibernate left without pin interrupt");
    a_hib_resume: assert property (st_ff.mode == pm_seq_pkg::M_HIB && ev[pm_seq_pkg::WK_IO]
                                   |=> st_ff.wait_cnt == CW'(HIB_RESUME_CYC - 1) && PIN_HOLD)
        else $error("hibernate resume wait wrong");
    a_hib_keep: assert property (st_ff.mode == pm_seq_pkg::M_HIB |-> PIN_HOLD && SRAM_RETAIN)
        else $error("hibernate lost hold or retention");
    a_no_self_low: assert property ((st_ff.mode == pm_seq_pkg::M_ACTIVE || st_ff.mode == pm_seq_pkg::M_ALT)
                                    && !go_low |=> st_ff.mode != pm_seq_pkg::M_SLEEP
                                    && st_ff.mode != pm_seq_pkg::M_HIB)
        else $error("low power entered without request");
    a_cause_set: assert property (ev[pm_seq_pkg::WK_WDOG] |=> st_ff.cause[pm_seq_pkg::WK_WDOG])
        else $error("wake cause not recorded");

    c_sleep_wake: cover property (st_ff.mode == pm_seq_pkg::M_SLEEP ##1 st_ff.mode == pm_seq_pkg::M_RESUME);
    c_hib_wake: cover property (st_ff.mode == pm_seq_pkg::M_HIB ##1 st_ff.mode == pm_seq_pkg::M_RESUME);
    c_alt_entry: cover property (st_ff.mode == pm_seq_pkg::M_ALT);
    c_tick_wake: cover property (st_ff.mode == pm_seq_pkg::M_SLEEP && ev[pm_seq_pkg::WK_TICK]);

endmodule

// >>> tb/wake_src_model.sv
// Partner model: the wake sources that stand around the power mode sequencer.
`timescale 1ns/10ps
module wake_src_model (
    // Clock
    input  wire logic       clk,
    // Wake levels
    output logic      [3:0] periph_irq,
    output logic            supv_irq,
    output logic            io_irq,
    output logic            ext_rst_n,
    output logic            wdog,
    output logic            prec_rst
);
    logic [6:0] lvl = 7'h00;
    assign periph_irq = {3'h0, lvl[0]};
    assign supv_irq   = lvl[1];
    assign io_irq     = lvl[3];
    assign ext_rst_n  = ~lvl[4];
    assign wdog       = lvl[5];
    assign prec_rst   = lvl[6];
    // =========================================
    // Events
    // One slow pulse per event keeps pin activity far below the hibernate limit.
    task automatic pulse(input int idx);
        @(posedge clk);
        lvl[idx] <= 1'b1;
        repeat (8) @(posedge clk);
        lvl[idx] <= 1'b0;
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the power mode sequencer.
`timescale 1ns/10ps
module tb_top;
    logic        clk, rstn, cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, dat_o, q;
    logic        ack_o, cpu_en, low_pwr, pin_hold, retain, tick_irq;
    logic        supv, io, xrn, wdog, prec;
    logic [3:0]  periph;
    logic [7:0]  clk_en, bias_en;
    logic [2:0]  mode;
    int          n_mismatch, checks, n;
    pm_seq #(.HIB_RESUME_CYC(20)) pm_seq_i (.CLK(clk), .RSTN(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack_o), .PERIPH_IRQ(periph),
        .SUPV_IRQ(supv), .IO_IRQ(io), .EXTERNAL_RESET_PIN_N(xrn), .WATCHDOG_TIMEOUT(wdog),
        .PRECISION_SUPPLY_RESET(prec), .RES_CLK_EN(clk_en), .RES_BIAS_EN(bias_en), .CPU_EN(cpu_en),
        .REG_LOW_POWER(low_pwr), .PIN_HOLD(pin_hold), .SRAM_RETAIN(retain), .TICK_IRQ(tick_irq),
        .POWER_MODE(mode));
    wake_src_model wake_src_model_i (.clk(clk), .periph_irq(periph), .supv_irq(supv), .io_irq(io),
        .ext_rst_n(xrn), .wdog(wdog), .prec_rst(prec));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // =========================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // The request stands until the edge that samples ACK_O high; read data is taken at that same edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        int k;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        q = dat_o;
        chk(ack_o, 1'b1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wt(input logic [2:0] m);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (mode !== m && n < 5000);
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    // =========================================
    // Scenarios
    task automatic t_reset();
        @(negedge clk);
        chk(mode, 3'h0);
        chk(clk_en, 8'hFF);
        wb(1'b0, pm_seq_pkg::OFS_WAKE_EN, 32'h0);
        chk(q, 32'h7F);
        wb(1'b0, pm_seq_pkg::OFS_TICK_PER, 32'h0);
        chk(q, 32'h3E8);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_tmpl();
        wb(1'b1, pm_seq_pkg::OFS_ACT_TMPL, 32'hA4);
        settle();
        chk(clk_en, 8'hA4);
        chk(bias_en, 8'hA4);
        chk(cpu_en, 1'b0);
        wake_src_model_i.pulse(4);
        repeat (4) @(negedge clk);
        chk(cpu_en, 1'b1);
        chk(clk_en, 8'hA5);
        $display("t_tmpl done");
    endtask
    task automatic t_alt();
        wb(1'b1, pm_seq_pkg::OFS_ALT_TMPL, 32'h0C);
        wb(1'b1, pm_seq_pkg::OFS_MODE, {29'h0, pm_seq_pkg::CMD_ALT});
        settle();
        chk(mode, 3'h1);
        chk(clk_en, 8'h0C);
        repeat (20) @(negedge clk);
        chk(mode, 3'h1);
        wake_src_model_i.pulse(0);
        repeat (4) @(negedge clk);
        chk(mode, 3'h0);
        chk(clk_en, 8'hA5);
        $display("t_alt done");
    endtask
    task automatic t_sleep();
        wb(1'b1, pm_seq_pkg::OFS_MODE, {29'h0, pm_seq_pkg::CMD_SLEEP});
        settle();
        chk(mode, 3'h2);
        chk(low_pwr, 1'b1);
        wake_src_model_i.pulse(5);
        wt(3'h0);
        chk(n > 2990 && n <= 3000, 1'b1);
        chk(cpu_en, 1'b1);
        $display("t_sleep done");
    endtask
    task automatic t_hib();
        wb(1'b1, pm_seq_pkg::OFS_MODE, {29'h0, pm_seq_pkg::CMD_HIB});
        settle();
        chk(mode, 3'h3);
        chk(low_pwr, 1'b1);
        chk(retain, 1'b1);
        chk(pin_hold, 1'b1);
        wake_src_model_i.pulse(5);
        repeat (20) @(negedge clk);
        chk(mode, 3'h3);
        wake_src_model_i.pulse(3);
        wt(3'h0);
        chk(n <= 20, 1'b1);
        $display("t_hib done");
    endtask
    task automatic t_cause();
        wb(1'b1, pm_seq_pkg::OFS_WAKE_CAUSE, 32'h7F, 4'h1);
        wb(1'b0, pm_seq_pkg::OFS_WAKE_CAUSE, 32'h0);
        chk(q, 32'h0);
        wake_src_model_i.pulse(1);
        wb(1'b0, pm_seq_pkg::OFS_WAKE_CAUSE, 32'h0);
        chk(q, 32'h02);
        wb(1'b1, pm_seq_pkg::OFS_WAKE_CAUSE, 32'h02, 4'h1);
        wake_src_model_i.pulse(6);
        wb(1'b0, pm_seq_pkg::OFS_WAKE_CAUSE, 32'h0);
        chk(q, 32'h40);
        wb(1'b1, pm_seq_pkg::OFS_WAKE_EN, 32'h0, 4'hE);
        wb(1'b0, pm_seq_pkg::OFS_WAKE_EN, 32'h0);
        chk(q, 32'h7F);
        wb(1'b1, pm_seq_pkg::OFS_MODE, {29'h0, pm_seq_pkg::CMD_ALT});
        wb(1'b1, pm_seq_pkg::OFS_MODE, {29'h0, pm_seq_pkg::CMD_ACTIVE});
        wb(1'b0, pm_seq_pkg::OFS_MODE, 32'h0);
        chk(q, 32'h0);
        chk(clk_en, 8'hA5);
        $display("t_cause done");
    endtask
    task automatic t_tick();
        wb(1'b1, pm_seq_pkg::OFS_TICK_PER, 32'h2);
        n = 0;
        while (tick_irq !== 1'b1 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (tick_irq !== 1'b1 && n < 1000);
        chk(n, 2 * pm_seq_pkg::TICK_DIV_CYC);
        $display("t_tick done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // =========================================
    // Main sequence and watchdog
    initial
    begin
        rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
        adr = 8'h00; sel = 4'h0; dat = 32'h0;
        n_mismatch = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_tmpl();
        t_alt();
        t_sleep();
        t_hib();
        t_cause();
        t_tick();
        finish_test();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule
